// ==== design/byte_buffer_ram.sv ====
`timescale 1ns/100ps
// ==========================================================
// Byte buffer memory with registered read data
module byte_buffer_ram #(
  parameter int AW = 8,
  parameter int DW = 8
) (
  input  wire logic          clk,
  input  wire logic          wr_en,
  input  wire logic [AW-1:0] wr_addr,
  input  wire logic [DW-1:0] wr_data,
  input  wire logic [AW-1:0] rd_addr,
  output logic      [DW-1:0] rd_data
);
  logic [DW-1:0] mem [0:(1<<AW)-1];
  logic [DW-1:0] rd_data_d;

  // Read port looks up combinationally, then registers
  always_comb begin
    rd_data_d = mem[rd_addr];
  end

  // Storage and read register; no reset on memory contents
  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= rd_data_d;
  end
endmodule // byte_buffer_ram

// ==== design/dma_handshake_slave_port.sv ====
// How it works
// - Acknowledge low drops a pending request
// - Bad write strobe order blocks further requests
// - Acknowledge high allows the next request
// - Read byte held until acknowledge rises
// - Clock counts use the device clock
`timescale 1ns/100ps
`include "dma_port_consts.svh"
module dma_handshake_slave_port #(
  parameter int AW         = 8,
  parameter int DW         = 8,
  parameter int QUIET_CLKS = `IO_QUIET_CLOCKS
) (
  input  wire logic                  clk,
  input  wire logic                  reset,
  input  wire logic                  reset_in_n,
  input  wire logic                  dma_ack_n,
  input  wire logic                  write_strobe_n,
  input  wire logic                  read_strobe_n,
  input  wire logic [DW-1:0]         data_in,
  input  wire dma_port_pkg::dir_t    dir,
  input  wire logic                  xfer_enable,
  input  wire logic [AW-1:0]         start_addr,
  input  wire logic                  start_load,
  input  wire logic                  sink_ready,
  output logic                       dma_request_n,
  output logic      [DW-1:0]         data_out,
  output logic                       data_oe,
  output logic                       sink_valid,
  output logic      [DW-1:0]         sink_data,
  output logic                       order_error,
  output logic                       port_ready
);
  import dma_port_pkg::*;

  // ==========================================================
  // Pin synchronisers: two flops before any logic
  logic [3:0] sync1_q;
  logic [3:0] sync2_q;
  logic [3:0] pins;
  logic       rst_in_s;
  logic       ack_s;
  logic       wr_s;
  logic       rd_s;
  logic       wr_prev_q;
  logic       wr_fall;

  always_comb begin
    pins = {reset_in_n, dma_ack_n, write_strobe_n, read_strobe_n};
  end

  // Synchroniser chain; second stage is the only reader of the first
  always_ff @(posedge clk) begin
    if (reset) begin
      sync1_q <= 4'h7; // Pin reset reads as asserted until sampled, no false release
      sync2_q <= 4'h7;
    end else begin
      sync1_q <= pins;
      sync2_q <= sync1_q;
    end
  end

  always_comb begin
    rst_in_s = sync2_q[3];
    ack_s    = sync2_q[2];
    wr_s     = sync2_q[1];
    rd_s     = sync2_q[0];
    wr_fall  = wr_prev_q & ~wr_s;
  end

  // ==========================================================
  // Sequencer state
  localparam int CYC_PS      = `CLK_PERIOD_PS;
  localparam int WR_GAP_CLKS = (`WR_CYCLE_NS * 1000 + CYC_PS - 1) / CYC_PS;
  localparam int RD_GAP_CLKS = (`RD_CYCLE_NS * 1000 + CYC_PS - 1) / CYC_PS;
  localparam int DEV_PER_PS  = 1000000000 / (`DEV_CLK_HZ / 1000); // Device period in ps keeps products in int
  localparam int QUIET_CYC   = (QUIET_CLKS * DEV_PER_PS + CYC_PS - 1) / CYC_PS;
  localparam int HOLD_CYC    = (`RESET_HOLD_CLOCKS * DEV_PER_PS + CYC_PS - 1) / CYC_PS;
  localparam int CW          = 8;

  port_state_t   state_q, state_d;
  logic [CW-1:0] cnt_q, cnt_d;
  logic [AW-1:0] addr_q, addr_d;
  logic          req_n_q, req_n_d;
  logic          err_q, err_d;
  logic          wrote_q, wrote_d;
  logic          oe_q, oe_d;
  logic          rdy_q, rdy_d;
  logic [DW-1:0] ram_rd;
  logic          ram_we;
  logic          buf_in_ready;

  function automatic logic [CW-1:0] clk_count(input int n);
    clk_count = CW'(n < 1 ? 1 : n);
  endfunction

  // Next-state logic; the device clock cycle is scaled to ours
  always_comb begin
    state_d = state_q;
    cnt_d   = cnt_q;
    addr_d  = addr_q;
    req_n_d = req_n_q;
    err_d   = err_q;
    wrote_d = wrote_q;
    oe_d    = oe_q;
    rdy_d   = rdy_q;
    ram_we  = 1'b0;
    unique case (state_q)
      ST_RESET: begin
        req_n_d = 1'b1;
        oe_d    = 1'b0;
        rdy_d   = 1'b0;
        if (rst_in_s) begin
          // Short pulses below the hold time are still honoured
          state_d = ST_QUIET;
          cnt_d   = clk_count(QUIET_CYC);
        end
      end
      ST_QUIET: begin
        if (cnt_q <= 8'h01) begin
          state_d = ST_IDLE;
          rdy_d   = 1'b1;
        end else begin
          cnt_d = cnt_q - 8'h01;
        end
      end
      ST_IDLE: begin
        if (cnt_q != 8'h00) begin
          cnt_d = cnt_q - 8'h01;
        end else if (xfer_enable && ack_s && (dir == DIR_READ || buf_in_ready)) begin
          req_n_d = 1'b0;
          state_d = ST_REQ;
        end
      end
      ST_REQ: begin
        if (!ack_s) begin
          req_n_d = 1'b1;
          wrote_d = 1'b0;
          state_d = ST_ACK;
          oe_d    = (dir == DIR_READ);
        end else if (dir == DIR_WRITE && !wr_s) begin
          req_n_d = 1'b1;
          err_d   = 1'b1;
          state_d = ST_STUCK;
        end
      end
      ST_ACK: begin
        if (dir == DIR_WRITE && wr_fall && !wrote_q) begin
          ram_we  = 1'b1;
          wrote_d = 1'b1;
        end
        if (ack_s) begin
          oe_d    = 1'b0;
          if (dir == DIR_READ || wrote_q) begin
            addr_d = addr_q + AW'(1);
            cnt_d  = clk_count(dir == DIR_READ ? RD_GAP_CLKS : WR_GAP_CLKS);
            state_d = ST_IDLE;
          end else begin
            err_d   = 1'b1;
            state_d = ST_STUCK;
          end
        end
      end
      ST_STUCK: begin
        req_n_d = 1'b1;
      end
      default: begin
        state_d = ST_RESET;
      end
    endcase
    if (start_load && state_q != ST_ACK) begin
      addr_d = start_addr;
    end
    if (!rst_in_s) begin
      state_d = ST_RESET;
      req_n_d = 1'b1;
      oe_d    = 1'b0;
      rdy_d   = 1'b0;
      err_d   = 1'b0;
      cnt_d   = CW'(HOLD_CYC);
    end
  end

  // Sequencer registers
  always_ff @(posedge clk) begin
    if (reset) begin
      state_q   <= ST_RESET;
      cnt_q     <= 8'h00;
      addr_q    <= AW'(`ADDR_RESET);
      req_n_q   <= 1'b1;
      err_q     <= 1'b0;
      wrote_q   <= 1'b0;
      oe_q      <= 1'b0;
      rdy_q     <= 1'b0;
      wr_prev_q <= 1'b1;
    end else begin
      state_q   <= state_d;
      cnt_q     <= cnt_d;
      addr_q    <= addr_d;
      req_n_q   <= req_n_d;
      err_q     <= err_d;
      wrote_q   <= wrote_d;
      oe_q      <= oe_d;
      rdy_q     <= rdy_d;
      wr_prev_q <= wr_s;
    end
  end

  // ==========================================================
  // Buffer memory; read byte is addressed ahead so it is ready at ack
  byte_buffer_ram #(.AW(AW), .DW(DW)) u_ram (
    .clk     (clk),
    .wr_en   (ram_we),
    .wr_addr (addr_q),
    .wr_data (data_in),
    .rd_addr (addr_q),
    .rd_data (ram_rd)
  );

  // ==========================================================
  // Two-entry skid buffer toward the sink, so a stall loses no byte
  logic [DW-1:0] b0_q, b0_d, b1_q, b1_d;
  logic [1:0]    n_q, n_d;
  logic [DW-1:0] dout_q, dout_d;
  logic          valid_q, valid_d;

  always_comb begin
    buf_in_ready = (n_q != 2'h2);
    b0_d = b0_q;
    b1_d = b1_q;
    n_d  = n_q;
    if (sink_ready && n_q != 2'h0) begin
      b0_d = b1_q;
      n_d  = n_q - 2'h1;
    end
    if (ram_we) begin
      if (n_d == 2'h0) begin
        b0_d = data_in;
      end else begin
        b1_d = data_in;
      end
      n_d = n_d + 2'h1;
    end
    dout_d = oe_d ? ram_rd : dout_q;
    valid_d = (n_d != 2'h0);
  end

  // Buffer and read data registers
  always_ff @(posedge clk) begin
    if (reset) begin
      b0_q   <= '0;
      b1_q   <= '0;
      n_q    <= 2'h0;
      dout_q <= '0;
      valid_q <= 1'b0;
    end else begin
      b0_q   <= b0_d;
      b1_q   <= b1_d;
      n_q    <= n_d;
      dout_q <= dout_d;
      valid_q <= valid_d;
    end
  end

  // Outputs straight from flops
  assign dma_request_n = req_n_q;
  assign data_out      = dout_q;
  assign data_oe       = oe_q;
  assign sink_valid    = valid_q;
  assign sink_data     = b0_q;
  assign order_error   = err_q;
  assign port_ready    = rdy_q;
endmodule // dma_handshake_slave_port

// ==== design/dma_port_consts.svh ====
`ifndef DMA_PORT_CONSTS_SVH
`define DMA_PORT_CONSTS_SVH
// ==========================================================
// Timing figures, clock rate and reset values
`define CLK_PERIOD_PS      5000
`define WR_CYCLE_NS        150
`define RD_CYCLE_NS        150
`define RESET_HOLD_CLOCKS  16
`define IO_QUIET_CLOCKS    16
`define DEV_CLK_HZ         48000000
`define ADDR_RESET         8'h00
`endif

// ==== design/dma_port_pkg.sv ====
package dma_port_pkg;
  // ==========================================================
  // Port sequencer states, one-hot
  typedef enum logic [5:0] {
    ST_RESET = 6'h01,
    ST_QUIET = 6'h02,
    ST_IDLE  = 6'h04,
    ST_REQ   = 6'h08,
    ST_ACK   = 6'h10,
    ST_STUCK = 6'h20
  } port_state_t;
  typedef enum logic {
    DIR_WRITE = 1'b0,
    DIR_READ  = 1'b1
  } dir_t;
endpackage

// ==== verification/dma_ctrl_model.sv ====
`timescale 1ns/100ps
// ==========================================================
// External DMA controller model
module dma_ctrl_model (
  input  wire logic               clk,
  input  wire logic               go,
  input  wire logic               slow,
  input  wire logic               bad,
  input  wire dma_port_pkg::dir_t dir,
  input  wire logic               req_n,
  output logic                    ack_n,
  output logic                    wr_n,
  output logic                    rd_n,
  output logic              [7:0] dat,
  output int                      cnt
);
  import dma_port_pkg::*;
  // One byte per request, strobe nested inside the ack window
  initial begin
    ack_n = 1'b1;
    wr_n = 1'b1;
    rd_n = 1'b1;
    dat = 8'h00;
    cnt = 0;
    forever begin
      @(posedge clk);
      if (go && !req_n) begin
        #1 wr_n = !bad; // Strobe ahead of ack only when asked
        @(posedge clk);
        #1 ack_n = 1'b0;
        dat = 8'h5a + cnt[7:0];
        repeat (slow ? 20 : 12) @(posedge clk);
        #1 wr_n = (dir == DIR_READ);
        rd_n = (dir != DIR_READ);
        repeat (19) @(posedge clk);
        #1 wr_n = 1'b1;
        rd_n = 1'b1;
        @(posedge clk);
        #1 dat = ~dat; // Hold time over, so show no stale byte
        repeat (3) @(posedge clk);
        #1 ack_n = 1'b1;
        cnt++;
        repeat (30) @(posedge clk);
      end
    end
  end
endmodule // dma_ctrl_model

// ==== verification/dma_port_checker.sv ====
`timescale 1ns/100ps
// ==========================================================
// Port rule checker
module dma_port_checker (
  input wire logic       clk,
  input wire logic       reset,
  input wire logic       reset_in_n,
  input wire logic       dma_ack_n,
  input wire logic       dma_request_n,
  input wire logic [7:0] data_out,
  input wire logic       data_oe,
  input wire logic       sink_valid,
  input wire logic       sink_ready,
  input wire logic [7:0] sink_data,
  input wire logic       order_error,
  input wire logic       port_ready
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  // Pin latency is two sync flops plus one register
  chk_ack_drops_req: assert property (!dma_request_n && $fell(dma_ack_n) |-> ##[1:4] dma_request_n)
    else $error("request not withdrawn");
  chk_error_blocks: assert property (order_error [*2] |-> dma_request_n)
    else $error("request after order error");
  chk_req_ack_high: assert property ($fell(dma_request_n) |-> dma_ack_n && port_ready)
    else $error("request while ack low");
  chk_read_stable: assert property (data_oe && $past(data_oe) |-> $stable(data_out))
    else $error("read byte moved");
  chk_gap_after: assert property ($rose(dma_ack_n) |=> dma_request_n [*8])
    else $error("request too soon");
  chk_pin_reset: assert property (!reset_in_n [*4] |-> dma_request_n && !port_ready && !data_oe)
    else $error("active under pin reset");
  chk_sys_reset: assert property (disable iff (1'b0) $fell(reset) |-> dma_request_n && !port_ready)
    else $error("active after reset");
  // A stalled consumer must see the same head byte
  chk_sink_hold: assert property (sink_valid && !sink_ready |=> sink_valid && $stable(sink_data))
    else $error("buffer head lost");
endmodule // dma_port_checker

bind dma_handshake_slave_port dma_port_checker dma_port_checker_inst (
  .clk(clk), .reset(reset), .reset_in_n(reset_in_n), .dma_ack_n(dma_ack_n), .dma_request_n(dma_request_n),
  .data_out(data_out), .data_oe(data_oe), .sink_valid(sink_valid), .sink_ready(sink_ready),
  .sink_data(sink_data), .order_error(order_error), .port_ready(port_ready));

// ==== verification/tb.sv ====
`timescale 1ns/100ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin err_total++; $display("Error %0t bad %h", $time, a); end end
// ==========================================================
// Testbench top
module tb;
  import dma_port_pkg::*;
  logic       clk, reset, reset_in_n, xfer_enable, start_load, sink_ready, slow, bad;
  logic       dma_ack_n, write_strobe_n, read_strobe_n, dma_request_n, data_oe, sink_valid, order_error, port_ready;
  logic [7:0] data_in, start_addr, data_out, sink_data, rd_byte;
  dir_t       dir;
  int         err_total, n_tests, cnt, nrx, c0;
  dma_handshake_slave_port dma_handshake_slave_port_inst (.clk, .reset, .reset_in_n, .dma_ack_n, .write_strobe_n,
    .read_strobe_n, .data_in, .dir, .xfer_enable, .start_addr, .start_load, .sink_ready, .dma_request_n,
    .data_out, .data_oe, .sink_valid, .sink_data, .order_error, .port_ready);
  dma_ctrl_model dma_ctrl_model_inst (.clk, .go(xfer_enable), .slow, .bad, .dir, .req_n(dma_request_n),
    .ack_n(dma_ack_n), .wr_n(write_strobe_n), .rd_n(read_strobe_n), .dat(data_in), .cnt);
  initial clk = 1'b0;
  always #2.5 clk = ~clk;
  // Written bytes must leave the buffer in order
  always @(posedge clk) if (sink_valid === 1'b1 && sink_ready === 1'b1) begin
    `CHK(sink_data, 8'h5a + nrx[7:0])
    nrx++;
  end
  task automatic wait_cnt(input int n);
    repeat (400) if (cnt < n) @(posedge clk);
    #1 `CHK(cnt, n)
  endtask
  task automatic stop_test();
    $display("comparisons %0d errors %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // Pin reset held 80 cycles, longer than sixteen device clocks
  task automatic test_pin_reset();
    repeat (60) @(posedge clk);
    #1 reset_in_n = 1'b1;
    repeat (66) @(posedge clk);
    #1 `CHK(port_ready, 1'b0)
    repeat (10) @(posedge clk);
    #1 `CHK(port_ready, 1'b1)
    `CHK(dma_request_n, 1'b1)
    $display("pin reset done");
  endtask
  task automatic test_writes();
    xfer_enable = 1'b1;
    wait_cnt(2);
    slow = 1'b1;
    wait_cnt(3);
    xfer_enable = 1'b0;
    repeat (40) @(posedge clk);
    #1 `CHK(nrx, 3)
    $display("writes done");
  endtask
  // Stalled consumer: two entries fill, then requests stop
  task automatic test_full();
    sink_ready = 1'b0;
    xfer_enable = 1'b1;
    repeat (300) @(posedge clk);
    #1 `CHK(cnt, 5)
    sink_ready = 1'b1;
    wait_cnt(6);
    xfer_enable = 1'b0;
    repeat (40) @(posedge clk);
    #1 `CHK(nrx, 6)
    `CHK(sink_valid, 1'b0)
    $display("buffer done");
  endtask
  task automatic test_read();
    dir = DIR_READ;
    start_load = 1'b1;
    @(posedge clk);
    #1 start_load = 1'b0;
    xfer_enable = 1'b1;
    @(negedge dma_ack_n);
    repeat (8) @(posedge clk);
    #1 rd_byte = data_out;
    `CHK(data_oe, 1'b1)
    `CHK(data_out, 8'h5a)
    @(posedge read_strobe_n);
    repeat (2) @(posedge clk);
    #1 `CHK(data_out, rd_byte)
    `CHK(data_oe, 1'b1)
    xfer_enable = 1'b0;
    @(posedge dma_ack_n);
    repeat (5) @(posedge clk);
    #1 `CHK(data_oe, 1'b0)
    $display("read done");
  endtask
  task automatic test_bad();
    dir = DIR_WRITE;
    bad = 1'b1;
    xfer_enable = 1'b1;
    wait_cnt(8);
    repeat (200) @(posedge clk);
    #1 `CHK(order_error, 1'b1)
    `CHK(cnt, 8)
    // Mid-run pin reset must clear the sticky error
    xfer_enable = 1'b0;
    bad = 1'b0;
    reset_in_n = 1'b0;
    repeat (80) @(posedge clk);
    #1 `CHK(order_error, 1'b0)
    `CHK(dma_request_n, 1'b1)
    reset_in_n = 1'b1;
    repeat (76) @(posedge clk);
    #1 `CHK(port_ready, 1'b1)
    $display("order error done");
  endtask
  // Hang guard, several times the expected run
  initial begin
    #30us;
    err_total++;
    $display("Error %0t watchdog", $time);
    stop_test();
  end
  initial begin
    {reset, reset_in_n, xfer_enable, start_load, sink_ready, slow, bad} = 7'h44;
    {start_addr, dir, err_total, n_tests, nrx} = 0;
    repeat (20) @(posedge clk);
    #1 reset = 1'b0;
    test_pin_reset();
    test_writes();
    test_full();
    test_read();
    test_bad();
    stop_test();
  end
endmodule // tb
